// ===== src/cms_defs.vh
`ifndef CMS_DEFS_VH
`define CMS_DEFS_VH
// ****************************************
// control word layout
// ****************************************
`define CMS_CTL_W          8
`define CMS_BIT_IRQ_EN     7
`define CMS_BIT_MON_FLAG   6
`define CMS_BIT_MON_ON     5
`define CMS_BIT_SRC_SEL    4
`define CMS_BIT_EXT_ON     3
`define CMS_BIT_EXT_STABLE 2
`define CMS_BIT_INT_ON     1
`define CMS_BIT_INT_STABLE 0
`define CMS_CTL_RESET      8'h02
// ****************************************
// timing counts
// ****************************************
`define CMS_SETTLE_CYCLES  4096
`define CMS_SETTLE_W       12
`define CMS_MISS_LIMIT     2'h2
`endif

// ===== src/cms_clock_monitor.v
`include "cms_defs.vh"
module cms_clock_monitor #(
    parameter SETTLE_CYCLES = `CMS_SETTLE_CYCLES
) (
    // clock and reset
    input  wire       core_clk,
    input  wire       reset_n,
    // sampled clock sources and references
    input  wire       baseClockLow,
    input  wire       intClock,
    input  wire       extClock,
    input  wire       extReference,
    input  wire       intReference,
    input  wire       intFreqGood,
    // control write
    input  wire       ctlWrite,
    input  wire [7:0] ctlWdata,
    input  wire       flagClear,
    // status and clocks
    output reg  [7:0] ctlStatus,
    output reg        intInactive,
    output reg        extInactive,
    output reg        extSettleClock,
    output reg        oscOutClock,
    output reg        genOutClock,
    output reg        irqRequest
);

    // ****************************************
    // edge detection
    // ****************************************
    localparam NSRC = 5;

    // sampled levels: base, external, ext ref, int ref, internal
    wire [NSRC-1:0] srcNow = {intClock, intReference, extReference, extClock, baseClockLow};
    wire [NSRC-1:0] srcQ;

    // one history flop per level, low after reset like the idle pins
    genvar gi;
    generate
        for (gi = 0; gi < NSRC; gi = gi + 1) begin : gHist
            reg histQ;
            always @(posedge core_clk or negedge reset_n) begin
                if (!reset_n) begin
                    histQ <= 1'b0;
                end else begin
                    histQ <= srcNow[gi];
                end
            end
            assign srcQ[gi] = histQ;
        end
    endgenerate

    // edge of a sampled level against its history
    function edgeOf;
        input prev;
        input cur;
        input rising;
        begin
            edgeOf = rising ? (~prev & cur) : (prev & ~cur);
        end
    endfunction

    wire       baseFall = edgeOf(srcQ[0], srcNow[0], 1'b0);
    wire       extFall  = edgeOf(srcQ[1], srcNow[1], 1'b0);
    wire       extRise  = edgeOf(srcQ[1], srcNow[1], 1'b1);
    wire       eRefRise = edgeOf(srcQ[2], srcNow[2], 1'b1);
    wire       iRefRise = edgeOf(srcQ[3], srcNow[3], 1'b1);
    wire       intRise  = edgeOf(srcQ[4], srcNow[4], 1'b1);
    wire       intFall  = edgeOf(srcQ[4], srcNow[4], 1'b0);

    reg        intOn;
    reg        extOn;
    reg        intStable;
    reg        extStable;
    reg        srcSel;
    reg        monOn;
    reg        irqEn;
    reg        monFlag;

    // ****************************************
    // activity detectors
    // ****************************************
    reg        seenBase;
    reg        seenExt;
    reg  [1:0] missInt;
    reg  [1:0] missExt;

    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            seenBase    <= 1'b0;
            seenExt     <= 1'b0;
            missInt     <= 2'h0;
            missExt     <= 2'h0;
            intInactive <= 1'b0;
            extInactive <= 1'b0;
        end else begin
            // low phase ends on reference rise
            if (eRefRise) begin
                seenBase <= 1'b0;
                if (!seenBase && missInt != `CMS_MISS_LIMIT)
                    missInt <= missInt + 2'h1;
                if (!seenBase && missInt == `CMS_MISS_LIMIT - 2'h1)
                    intInactive <= 1'b1;
                if (seenBase)
                    missInt <= 2'h0;
            end else if (!extReference && baseFall) begin
                seenBase    <= 1'b1;
                missInt     <= 2'h0;
                intInactive <= 1'b0;
            end
            if (iRefRise) begin
                seenExt <= 1'b0;
                if (!seenExt && missExt != `CMS_MISS_LIMIT)
                    missExt <= missExt + 2'h1;
                if (!seenExt && missExt == `CMS_MISS_LIMIT - 2'h1)
                    extInactive <= 1'b1;
                if (seenExt)
                    missExt <= 2'h0;
            end else if (!intReference && extFall) begin
                seenExt     <= 1'b1;
                missExt     <= 2'h0;
                extInactive <= 1'b0;
            end
        end
    end

    // ****************************************
    // internal stability from frequency measurement
    // ****************************************
    reg  [1:0] goodCnt;

    // one measurement per reference period
    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            goodCnt   <= 2'h0;
            intStable <= 1'b0;
        end else if (!intOn || intInactive) begin
            goodCnt   <= 2'h0;
            intStable <= 1'b0;
        end else if (eRefRise) begin
            if (!intFreqGood) begin
                goodCnt   <= 2'h0;
                intStable <= 1'b0;
            end else if (goodCnt != 2'h2) begin
                goodCnt <= goodCnt + 2'h1;
                if (goodCnt == 2'h1)
                    intStable <= 1'b1;
            end
        end
    end

    // ****************************************
    // external stability from settle divider
    // ****************************************
    localparam SW = `CMS_SETTLE_W;

    reg  [SW-1:0] settleCnt;
    reg           settleFall;
    wire          settleLast = (settleCnt == SETTLE_CYCLES - 1);
    wire          settleHigh = (settleCnt >= SETTLE_CYCLES / 2 - 1) && !settleLast;

    // divider counts external falls until the settle clock falls
    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            settleCnt      <= {SW{1'b0}};
            extSettleClock <= 1'b0;
            settleFall     <= 1'b0;
        end else if (!extOn) begin
            settleCnt      <= {SW{1'b0}};
            extSettleClock <= 1'b0;
            settleFall     <= 1'b0;
        end else if (extFall && !extStable) begin
            // restart after the last count so a lost stable bit waits a full period again
            if (settleLast)
                settleCnt <= {SW{1'b0}};
            else
                settleCnt <= settleCnt + 1'b1;
            extSettleClock <= settleHigh;
            settleFall     <= settleLast;
        end else begin
            settleFall     <= 1'b0;
        end
    end

    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n)
            extStable <= 1'b0;
        else if (!extOn || extInactive)
            extStable <= 1'b0;
        else if (settleFall)
            extStable <= 1'b1;
    end

    // ****************************************
    // control bits
    // ****************************************
    // a clock may be chosen by a write or watched only while on and stable
    function clockReady;
        input on;
        input stable;
        begin
            clockReady = on & stable;
        end
    endfunction

    wire wSel   = ctlWdata[`CMS_BIT_SRC_SEL];
    wire wIntOn = ctlWdata[`CMS_BIT_INT_ON];
    wire wMonOn = ctlWdata[`CMS_BIT_MON_ON];
    wire wIrqEn = ctlWdata[`CMS_BIT_IRQ_EN];
    wire selOk  = wSel ? clockReady(extOn, extStable) : clockReady(intOn, intStable);
    wire monOk  = clockReady(intOn, intStable) && clockReady(extOn, extStable);
    wire anyOff = intInactive | extInactive;

    // generator enables; the internal clock cannot be switched off while in use
    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            intOn <= 1'b1;
            extOn <= 1'b0;
        end else if (ctlWrite) begin
            extOn <= ctlWdata[`CMS_BIT_EXT_ON];
            if (wIntOn || srcSel)
                intOn <= wIntOn;
        end
    end

    // source select; monitor forcing overrides a write
    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            srcSel <= 1'b0;
        end else if (monOn && intInactive) begin
            srcSel <= 1'b1;
        end else if (monOn && extInactive) begin
            srcSel <= 1'b0;
        end else if (ctlWrite && wSel != srcSel && selOk && intOn && extOn) begin
            srcSel <= wSel;
        end
    end

    // monitor enable and its interrupt enable
    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            monOn <= 1'b0;
            irqEn <= 1'b0;
        end else if (ctlWrite) begin
            if (!wMonOn)
                monOn <= 1'b0;
            else if (monOk)
                monOn <= 1'b1;
            if (!wIrqEn)
                irqEn <= 1'b0;
            else if (monOn)
                irqEn <= 1'b1;
        end
    end

    // monitor flag; a new inactivity wins over a clear
    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n)
            monFlag <= 1'b0;
        else if (monOn && anyOff)
            monFlag <= 1'b1;
        else if (flagClear)
            monFlag <= 1'b0;
    end

    // ****************************************
    // two-sided switch synchronizer
    // ****************************************
    reg [1:0] intSide;
    reg [1:0] extSide;
    wire      forceInt = monOn && extInactive;
    wire      forceExt = monOn && intInactive;
    wire      anyEdge  = intRise | intFall | extRise | extFall;

    // old side drops first, new side waits for it
    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            intSide <= 2'h3;
            extSide <= 2'h0;
        end else begin
            if (forceExt)
                intSide <= 2'h0;
            else if (intFall)
                intSide <= {intSide[0], ~srcSel & ~extSide[1]};
            if (forceInt)
                extSide <= 2'h0;
            else if (extFall)
                extSide <= {extSide[0], srcSel & ~intSide[1]};
        end
    end

    // output copy of the selected side and its half-rate divider
    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            oscOutClock <= 1'b0;
            genOutClock <= 1'b0;
        end else begin
            if (anyEdge)
                oscOutClock <= (intSide[1] & intClock) | (extSide[1] & extClock);
            if (intSide[1] ? intRise : (extSide[1] && extRise))
                genOutClock <= ~genOutClock;
        end
    end

    // ****************************************
    // status
    // ****************************************
    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            ctlStatus  <= `CMS_CTL_RESET;
            irqRequest <= 1'b0;
        end else begin
            ctlStatus  <= {irqEn, monFlag, monOn, srcSel, extOn, extStable, intOn, intStable};
            irqRequest <= monFlag & irqEn;
        end
    end

endmodule

// ===== verification/cms_clock_monitor_props.sv
module cms_clock_monitor_props (
    // ****
    // watched ports
    // ****
    input wire       core_clk,
    input wire       reset_n,
    input wire [7:0] ctlStatus,
    input wire       intInactive,
    input wire       extInactive,
    input wire       oscOutClock,
    input wire       genOutClock,
    input wire       irqRequest
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    wire [7:0] s = ctlStatus;
    irq_level_a: assert property (irqRequest == (s[7] & s[6]))
        else $error("irq level wrong");
    irq_needs_mon_a: assert property ($rose(s[7]) |-> $past(s[5]))
        else $error("irq enable early");
    mon_guard_a: assert property ($rose(s[5]) |-> $past(s[3:0]) == 4'hf)
        else $error("monitor on early");
    sel_guard_a: assert property ($rose(s[4]) && !$past(s[5]) |-> $past(s[3:1]) == 3'h7)
        else $error("select early");
    int_keep_a: assert property ($fell(s[1]) |-> $past(s[4]))
        else $error("clock in use off");
    ext_drop_a: assert property (!s[3] || extInactive |-> ##[1:3] !s[2])
        else $error("ext stable kept");
    int_drop_a: assert property (intInactive |-> ##[1:3] !s[0])
        else $error("int stable kept");
    force_int_a: assert property (s[5] && extInactive |-> ##[1:4] !s[4])
        else $error("no forced select");
    flag_set_a: assert property (s[5] && (intInactive || extInactive) |-> ##[1:3] s[6])
        else $error("flag not set");
    half_rate_a: assert property ($rose(oscOutClock) |-> ##[0:1] $changed(genOutClock))
        else $error("no output toggle");
    cover property (s[4] && s[5]);
    cover property (extInactive && s[5]);
    cover property (irqRequest);
endmodule
bind cms_clock_monitor cms_clock_monitor_props u_cms_clock_monitor_props (
    .core_clk    (core_clk),
    .reset_n     (reset_n),
    .ctlStatus   (ctlStatus),
    .intInactive (intInactive),
    .extInactive (extInactive),
    .oscOutClock (oscOutClock),
    .genOutClock (genOutClock),
    .irqRequest  (irqRequest)
);

// ===== verification/tb_cms_clock_monitor.sv
module tb_cms_clock_monitor;
    timeunit 1ns;
    timeprecision 1ps;
    // ****
    // stimulus, model and checks
    // ****
    reg        core_clk = 0, reset_n = 0, baseClockLow = 0, intClock = 0, extClock = 0;
    reg        extReference = 0, intReference = 0, intFreqGood = 1, ctlWrite = 0, flagClear = 0;
    reg        extRun = 1, baseRun = 1;
    reg  [7:0] ctlWdata = 8'h00, st = 8'h02;
    wire [7:0] ctlStatus;
    wire       intInactive, extInactive, extSettleClock, oscOutClock, genOutClock, irqRequest;
    wire [9:0] obs = {intInactive, extInactive, ctlStatus};
    integer    seed = 37, fail_count = 0, checks = 0, cyc = 0, i;
    cms_clock_monitor #(.SETTLE_CYCLES(16)) u_cms_clock_monitor (
        .core_clk       (core_clk),
        .reset_n        (reset_n),
        .baseClockLow   (baseClockLow),
        .intClock       (intClock),
        .extClock       (extClock),
        .extReference   (extReference),
        .intReference   (intReference),
        .intFreqGood    (intFreqGood),
        .ctlWrite       (ctlWrite),
        .ctlWdata       (ctlWdata),
        .flagClear      (flagClear),
        .ctlStatus      (ctlStatus),
        .intInactive    (intInactive),
        .extInactive    (extInactive),
        .extSettleClock (extSettleClock),
        .oscOutClock    (oscOutClock),
        .genOutClock    (genOutClock),
        .irqRequest     (irqRequest)
    );
    initial forever #4 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        intClock <= #1 ~intClock;
        if (cyc % 3 == 0 && extRun) extClock <= #1 ~extClock;
        if (cyc % 4 == 0 && baseRun) baseClockLow <= #1 ~baseClockLow;
        if (cyc % 16 == 0) extReference <= #1 ~extReference;
        if (cyc % 12 == 0) intReference <= #1 ~intReference;
    end
    task results;
        if (fail_count == 0 && checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task chk(input [47:0] nm, input [7:0] e, input [7:0] g);
        checks = checks + 1;
        if (g !== e) begin
            fail_count = fail_count + 1;
            $display("[ERR] %0s exp %h got %h", nm, e, g);
        end
    endtask
    task wt(input integer k, input v);
        for (i = 0; i < 3000 && obs[k] !== v; i = i + 1) begin
            @(posedge core_clk);
            #1;
        end
        chk("wait", {7'h00, v}, {7'h00, obs[k]});
        if (i == 3000) results;
    endtask
    task wr(input [7:0] d);
        @(posedge core_clk);
        ctlWrite <= #1 1'b1;
        ctlWdata <= #1 d | ($random(seed) & 8'h45);
        @(posedge core_clk);
        ctlWrite <= #1 1'b0;
        st[7] = d[7] & st[5];
        st[5] = d[5] & (st[5] | st[3:0] == 4'hf);
        st[1] = d[1] | ~st[4];
        if (st[3] && st[1] && (d[4] ? st[2] : st[0])) st[4] = d[4];
        st[3] = d[3];
        repeat (2) @(posedge core_clk);
        #1 chk("status", st, ctlStatus);
    endtask
    task follow(input x);
        reg p;
        reg q;
        reg g;
        repeat (30) @(posedge core_clk);
        q = x ? extClock : intClock;
        #1 g = genOutClock;
        repeat (6) begin
            @(posedge core_clk);
            p = x ? extClock : intClock;
            #1 chk("osc", {7'h00, p}, {7'h00, oscOutClock});
            if (p && !q) g = ~g;
            chk("gen", {7'h00, g}, {7'h00, genOutClock});
            q = p;
        end
    endtask
    initial begin
        repeat (16) @(posedge core_clk);
        #1;
        chk("reset", 8'h02, ctlStatus);
        chk("outs", 8'h00, {2'h0, oscOutClock, genOutClock, irqRequest, intInactive, extInactive, 1'b0});
        reset_n = 1'b1;
        wr(8'h10);
        wr(8'ha2);
        wr(8'h0a);
        wt(2, 1'b1);
        chk("settle", 8'h00, {7'h00, extSettleClock});
        wt(0, 1'b1);
        st[2] = 1'b1;
        st[0] = 1'b1;
        wr(8'h3a);
        wr(8'hba);
        follow(1'b1);
        extRun = 0;
        wt(8, 1'b1);
        repeat (8) @(posedge core_clk);
        #1 chk("status", 8'heb, ctlStatus);
        chk("irq", 8'h01, {7'h00, irqRequest});
        follow(1'b0);
        extRun = 1;
        wt(8, 1'b0);
        flagClear <= #1 1'b1;
        @(posedge core_clk);
        flagClear <= #1 1'b0;
        repeat (3) @(posedge core_clk);
        #1 chk("flag", 8'h00, {6'h00, ctlStatus[6], irqRequest});
        baseRun = 0;
        wt(9, 1'b1);
        repeat (4) @(posedge core_clk);
        #1 chk("intstb", 8'h00, {7'h00, ctlStatus[0]});
        baseRun = 1;
        wt(9, 1'b0);
        wt(0, 1'b1);
        intFreqGood = ($random(seed) & 0) != 0;
        wt(0, 1'b0);
        results;
    end
endmodule
